// *** logic/itsc_params.svh ***
`ifndef ITSC_PARAMS_SVH
`define ITSC_PARAMS_SVH
// Register byte offsets on the APB
`define ITSC_RUN_OFFSET       12'h000
`define ITSC_SYNC_OFFSET      12'h004
`define ITSC_CNT0_OFFSET      12'h010
// Reset values of the two control registers, bit 7 held at zero, and of the counters
`define ITSC_RUN_RESET        8'h60
`define ITSC_SYNC_RESET       8'h60
`define ITSC_CNT_RESET        16'h0000
// Field layout
`define ITSC_CH_MSB           4
`define ITSC_FIXED_ONES       8'h60
`define ITSC_NUM_CH           5
`endif

// *** logic/itsc_pkg.sv ***
package itsc_pkg;
	typedef logic [7:0]  itsc_reg_t;
	typedef logic [4:0]  itsc_chmask_t;
	typedef logic [15:0] itsc_count_t;
	typedef enum logic [1:0] {ITSC_IDLE, ITSC_ACCESS} itsc_phase_e;
endpackage

// *** logic/itsc_channel.sv ***
`timescale 1ns/1ps
`include "itsc_params.svh"
// One channel counter: load beats clear, clear beats count
module itsc_channel (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	// Control
	input  wire logic                  run,
	input  wire logic                  load,
	input  wire logic                  clear,
	input  wire itsc_pkg::itsc_count_t load_value,
	// State
	output itsc_pkg::itsc_count_t      count
);
	itsc_pkg::itsc_count_t next_count;

	// Next counter value
	always_comb begin
		next_count = count;
		if (load) begin
			next_count = load_value;
		end else if (clear) begin
			next_count = `ITSC_CNT_RESET;
		end else if (run) begin
			next_count = count + 16'h0001; // see [RULE2]
		end
	end

	// Counter register, zero after reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= `ITSC_CNT_RESET; // see [RULE8]
		end else begin
			count <= next_count;
		end
	end
endmodule // itsc_channel

// *** logic/itsc_top.sv ***
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "itsc_params.svh"
// How it works
// [RULE1] Run register is 8 bits, resets to bits 6,5 one, rest zero.
// [RULE2] Run bit n makes channel n count; zero holds its counter.
// [RULE3] Bits 7..5 of run register ignore writes; 6,5 read one.
// [RULE4] Software writes ones into bits 6 and 5 of both registers.
// [RULE5] Sync register is 8 bits, resets like run register, bits 6,5 read one.
// [RULE6] Sync bit zero: channel preset and clear only by its own events.
// [RULE7] Channels with sync bit one form one synchronized group.
// [RULE8] Channel counters reset to zero and are readable and writable.
// [RULE9] Group member write loads all members; member clear clears all members.
module itsc_top (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Per-channel clear events from channel compare logic
	input  wire itsc_pkg::itsc_chmask_t clear_event,
	// Channel state to the rest of the timer
	output itsc_pkg::itsc_chmask_t     run_out,
	output itsc_pkg::itsc_chmask_t     group_out
);
	itsc_pkg::itsc_reg_t    run_reg;
	itsc_pkg::itsc_reg_t    sync_reg;
	itsc_pkg::itsc_reg_t    next_run_reg;
	itsc_pkg::itsc_reg_t    next_sync_reg;
	itsc_pkg::itsc_count_t  count [`ITSC_NUM_CH];
	itsc_pkg::itsc_chmask_t load_ch;
	itsc_pkg::itsc_chmask_t clear_ch;
	itsc_pkg::itsc_chmask_t wr_cnt;
	itsc_pkg::itsc_phase_e  phase;
	itsc_pkg::itsc_phase_e  next_phase;
	logic [31:0]            next_prdata;
	logic                   next_pready;
	logic                   next_pslverr;
	logic                   take;
	logic                   mapped;
	logic                   group_clear;
	logic                   group_write;
	itsc_pkg::itsc_chmask_t members;
	itsc_pkg::itsc_count_t  wr_value;

	// Take the request in the first access cycle; one wait state keeps the answer registered
	assign take     = psel && penable && (phase == itsc_pkg::ITSC_ACCESS);
	assign members  = sync_reg[`ITSC_CH_MSB:0];
	assign wr_value = pwdata[15:0];

	// Which counter is written this access
	always_comb begin
		wr_cnt = '0;
		for (int i = 0; i < `ITSC_NUM_CH; i++) begin
			if (take && pwrite && paddr == (`ITSC_CNT0_OFFSET + 12'(4 * i))) begin
				wr_cnt[i] = 1'b1;
			end
		end
	end

	// Group fan-out of presets and clears
	always_comb begin
		group_write = |(wr_cnt & members);    // see [RULE7]
		group_clear = |(clear_event & members);
		load_ch     = '0;
		clear_ch    = '0;
		for (int i = 0; i < `ITSC_NUM_CH; i++) begin
			if (members[i]) begin
				load_ch[i]  = group_write;        // see [RULE9]
				clear_ch[i] = group_clear;        // see [RULE9]
			end else begin
				load_ch[i]  = wr_cnt[i];          // see [RULE6]
				clear_ch[i] = clear_event[i];     // see [RULE6]
			end
		end
	end

	// Counters, one instance per channel
	for (genvar g = 0; g < `ITSC_NUM_CH; g++) begin : g_ch
		itsc_channel u_ch (
			.core_clk   (core_clk),
			.rst_n      (rst_n),
			.run        (run_reg[g]),
			.load       (load_ch[g]),
			.clear      (clear_ch[g]),
			.load_value (wr_value),
			.count      (count[g])
		);
	end

	// Bus decode, register writes and read mux
	always_comb begin
		next_run_reg  = run_reg;
		next_sync_reg = sync_reg;
		next_prdata   = prdata;
		next_pready   = 1'b0;
		next_pslverr  = 1'b0;
		next_phase    = phase;
		mapped        = (paddr == `ITSC_RUN_OFFSET) || (paddr == `ITSC_SYNC_OFFSET)
			|| (|wr_cnt);
		for (int i = 0; i < `ITSC_NUM_CH; i++) begin
			if (paddr == (`ITSC_CNT0_OFFSET + 12'(4 * i))) begin
				mapped = 1'b1;
			end
		end
		case (phase)
			itsc_pkg::ITSC_IDLE: begin
				if (psel && !penable) begin
					next_phase = itsc_pkg::ITSC_ACCESS;
				end
			end
			itsc_pkg::ITSC_ACCESS: begin
				if (take) begin
					next_pready  = 1'b1;
					next_pslverr = !mapped;
					next_prdata  = 32'h0000_0000;
					next_phase   = itsc_pkg::ITSC_IDLE;
					if (pwrite && paddr == `ITSC_RUN_OFFSET) begin
						// Reserved bits keep their value; software ones there are harmless
						next_run_reg = {run_reg[7:5], pwdata[4:0]}; // see [RULE3]
					end
					if (pwrite && paddr == `ITSC_SYNC_OFFSET) begin
						next_sync_reg = {sync_reg[7:5], pwdata[4:0]}; // see [RULE5]
					end
					if (!pwrite && paddr == `ITSC_RUN_OFFSET) begin
						next_prdata = {24'h00_0000, run_reg | `ITSC_FIXED_ONES}; // see [RULE3]
					end
					if (!pwrite && paddr == `ITSC_SYNC_OFFSET) begin
						next_prdata = {24'h00_0000, sync_reg | `ITSC_FIXED_ONES}; // see [RULE5]
					end
					for (int i = 0; i < `ITSC_NUM_CH; i++) begin
						if (!pwrite && paddr == (`ITSC_CNT0_OFFSET + 12'(4 * i))) begin
							next_prdata = {16'h0000, count[i]}; // see [RULE8]
						end
					end
				end
			end
			default: next_phase = itsc_pkg::ITSC_IDLE;
		endcase
	end

	// Bus and control registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_reg   <= `ITSC_RUN_RESET;  // see [RULE1]
			sync_reg  <= `ITSC_SYNC_RESET; // see [RULE5]
			prdata    <= 32'h0000_0000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			phase     <= itsc_pkg::ITSC_IDLE;
			run_out   <= 5'h00;
			group_out <= 5'h00;
		end else begin
			run_reg   <= next_run_reg;
			sync_reg  <= next_sync_reg;
			prdata    <= next_prdata;
			pready    <= next_pready;
			pslverr   <= next_pslverr;
			phase     <= next_phase;
			run_out   <= next_run_reg[`ITSC_CH_MSB:0];
			group_out <= next_sync_reg[`ITSC_CH_MSB:0];
		end
	end

	// Checks; reserved bits are only ever reloaded from themselves
	run_reset_a: assert property (@(posedge core_clk) // see [RULE1]
		$rose(rst_n) |-> run_reg == `ITSC_RUN_RESET)
		else $error("run register not at reset value");
	run_reserved_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE3]
		run_reg[7:5] == 3'h3)
		else $error("run reserved bits changed");
	sync_reserved_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE5]
		sync_reg[7:5] == 3'h3)
		else $error("sync reserved bits changed");
	count_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE2]
		(!run_reg[0] && !load_ch[0] && !clear_ch[0]) |=> $stable(count[0]))
		else $error("halted counter moved");
	count_run_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE2]
		(run_reg[1] && !load_ch[1] && !clear_ch[1])
		|=> count[1] == $past(count[1]) + 16'h0001)
		else $error("running counter did not step");
	indep_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE6]
		(!members[2] && !clear_event[2]) |-> !clear_ch[2])
		else $error("independent channel cleared by other");
	group_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE9]
		(members[0] && members[1] && clear_event[1] && !load_ch[0]) |=> count[0] == 16'h0000)
		else $error("group clear missed member");
	group_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // see [RULE7]
		(members[0] && members[1] && wr_cnt[0]) |=> count[1] == count[0])
		else $error("group write not shared");
	bus_answer_a: assert property (@(posedge core_clk) disable iff (!rst_n) // bus answer timing, our own choice
		(psel && !penable) ##1 (psel && penable) |=> pready)
		else $error("no answer one cycle into access");
	run_write_c: cover property (@(posedge core_clk) disable iff (!rst_n)
		take && pwrite && paddr == `ITSC_RUN_OFFSET);
	group_write_c: cover property (@(posedge core_clk) disable iff (!rst_n) group_write);
	group_clear_c: cover property (@(posedge core_clk) disable iff (!rst_n) group_clear);
endmodule // itsc_top

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "itsc_params.svh"
module testbench;
	logic                   core_clk, rst_n, psel, penable, pwrite, rerr;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata, rd, rd2;
	logic                   pready, pslverr;
	itsc_pkg::itsc_chmask_t clear_event, run_out, group_out;
	int                     err_total, num_checks, cyc;
	localparam logic [11:0] RUN = `ITSC_RUN_OFFSET;
	localparam logic [11:0] SYN = `ITSC_SYNC_OFFSET;
	itsc_top DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clear_event(clear_event), .run_out(run_out), .group_out(group_out));
	// Free-running 40 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Hang guard, well above the roughly two hundred cycles needed
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_total++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk5(input itsc_pkg::itsc_chmask_t got, input itsc_pkg::itsc_chmask_t exp);
		chk32({27'h0, got}, {27'h0, exp});
	endtask
	// One APB transfer; held until pready is seen at a rising edge
	task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= is_wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// No cycle count assumed; pready or else the hang guard ends this wait
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rdv(input logic [11:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask
	function automatic logic [11:0] cnt(input int n);
		return `ITSC_CNT0_OFFSET + 12'(4 * n);
	endfunction
	task automatic pulse(input itsc_pkg::itsc_chmask_t m);
		@(posedge core_clk);
		clear_event <= m;
		@(posedge core_clk);
		clear_event <= 5'h00;
	endtask
	task automatic do_reset();
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
	endtask
	// Main sequence; idle bus and no clear events at time zero
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		clear_event = 5'h00;
		err_total = 0;
		num_checks = 0;
		cyc = 0;
		do_reset();
		rdv(RUN, rd);
		chk32(rd, 32'h0000_0060);
		rdv(SYN, rd);
		chk32(rd, 32'h0000_0060);
		for (int i = 0; i < 5; i++) begin
			rdv(cnt(i), rd);
			chk32(rd, 32'h0000_0000);
		end
		chk5(run_out, 5'h00);
		chk5(group_out, 5'h00);
		$display("test reset values done");
		// Software always writes ones into bits 6 and 5; bit 7 may go either way
		wr(RUN, 32'h0000_00FF);
		rdv(RUN, rd);
		chk32(rd, 32'h0000_007F);
		wr(RUN, 32'h0000_0060);
		rdv(RUN, rd);
		chk32(rd, 32'h0000_0060);
		for (int i = 0; i < 5; i++) begin
			wr(RUN, 32'h60 | (32'h1 << i));
			chk5(run_out, 5'(1 << i));
		end
		wr(SYN, 32'h0000_00FF);
		rdv(SYN, rd);
		chk32(rd, 32'h0000_007F);
		chk5(group_out, 5'h1F);
		wr(SYN, 32'h0000_0060);
		rdv(SYN, rd);
		chk32(rd, 32'h0000_0060);
		$display("test register fields done");
		// Reads are four cycles apart, so a running counter moves by four
		wr(cnt(1), 32'h0000_1234);
		wr(RUN, 32'h0000_0061);
		rdv(cnt(0), rd);
		rdv(cnt(0), rd2);
		chk32(rd2 - rd, 32'h4);
		rdv(cnt(1), rd);
		chk32(rd, 32'h0000_1234);
		$display("test counting done");
		// All halted; channels 0 and 1 grouped, channel 2 preset on its own
		wr(RUN, 32'h0000_0060);
		wr(SYN, 32'h0000_0063);
		chk5(group_out, 5'h03);
		wr(cnt(2), 32'h0000_0000);
		wr(cnt(0), 32'h0000_0ABC);
		rdv(cnt(1), rd);
		chk32(rd, 32'h0000_0ABC);
		rdv(cnt(2), rd);
		chk32(rd, 32'h0000_0000);
		wr(cnt(2), 32'h0000_0055);
		rdv(cnt(0), rd);
		chk32(rd, 32'h0000_0ABC);
		pulse(5'h02);
		rdv(cnt(0), rd);
		chk32(rd, 32'h0000_0000);
		rdv(cnt(2), rd);
		chk32(rd, 32'h0000_0055);
		wr(cnt(1), 32'h0000_0077);
		pulse(5'h04);
		rdv(cnt(2), rd);
		chk32(rd, 32'h0000_0000);
		rdv(cnt(0), rd);
		chk32(rd, 32'h0000_0077);
		$display("test sync group done");
		// Unmapped place: error answer and no side effect
		apb(1'b1, 12'h0FC, 32'h0000_00FF, rd, rerr);
		chk32({31'h0, rerr}, 32'h1);
		apb(1'b0, 12'h0FC, 32'h0, rd, rerr);
		chk32(rd, 32'h0);
		rdv(RUN, rd);
		chk32(rd, 32'h0000_0060);
		$display("test unmapped done");
		// Reset in mid-run with every channel counting
		wr(RUN, 32'h0000_007F);
		do_reset();
		rdv(RUN, rd);
		chk32(rd, 32'h0000_0060);
		rdv(SYN, rd);
		chk32(rd, 32'h0000_0060);
		rdv(cnt(0), rd);
		chk32(rd, 32'h0000_0000);
		chk5(run_out, 5'h00);
		chk5(group_out, 5'h00);
		$display("test second reset done");
		conclude();
	end
endmodule // testbench
